// ---- slp_core_model.sv ----
/*
 core logic model: sends core words on request, takes receive
 symbols at a chosen pace (gap 0 stalls, 1 every cycle).
 assumes send_go is pulsed only while busy is low.
*/
`timescale 1ns/100ps
module slp_core_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [1:0]  tick_gap,
    input  wire logic        send_go,
    input  wire logic [19:0] send_word,
    output logic             busy,
    output logic      [19:0] tx_data,
    output logic             tx_data_valid,
    input  wire logic        tx_ready,
    output logic             rx_core_tick
);
    logic [1:0] gap_reg;
    assign busy = send_go || tx_data_valid;
    always @(posedge clk) begin
        if (reset) begin
            tx_data <= 20'h0;
            tx_data_valid <= 1'b0;
            rx_core_tick <= 1'b0;
            gap_reg <= 2'h0;
        end else begin
            // released word is inverted so stale data never passes
            if (tx_data_valid && tx_ready) begin
                tx_data_valid <= 1'b0;
                tx_data <= ~tx_data;
            end
            if (send_go) begin
                tx_data_valid <= 1'b1;
                tx_data <= send_word;
            end
            rx_core_tick <= (tick_gap != 2'h0) && (gap_reg == 2'h0);
            gap_reg <= (gap_reg >= tick_gap - 2'h1) ? 2'h0 : gap_reg + 2'h1;
        end
    end
endmodule

// ---- slp_dec.sv ----
/*
 8b/10b decoder, combinational; flags any code not in the tables.
 assumes bit 9 of the word is the first-received bit a.
*/
`timescale 1ns/100ps
module slp_dec
    import slp_pkg::*;
(
    input  wire logic [9:0] code,
    output logic      [7:0] data,
    output logic            k,
    output logic            err
);
    logic [5:0] c6;
    logic [3:0] c4;
    logic [4:0] x;
    logic [2:0] y;
    logic       ok6;
    logic       ok4;
    logic       pos;

    always_comb begin
        c6 = code[9:4];
        c4 = code[3:0];
        x = 5'h00;
        y = 3'h0;
        ok6 = 1'b0;
        ok4 = 1'b0;
        k = 1'b0;
        pos = (c6 == ~K28_6B);
        if (c6 == K28_6B || pos) begin
            k = 1'b1;
            x = 5'h1C;
            ok6 = 1'b1;
            for (int j = 0; j < 8; j++) begin
                if (c4 == (pos ? ~T4K[j] : T4K[j])) begin
                    y = 3'(j);
                    ok4 = 1'b1;
                end
            end
        end else begin
            for (int i = 0; i < 32; i++) begin
                if (c6 == T6[i] || (c6 == ~T6[i] &&
                    (($countones(T6[i]) != 3) || i == 7))) begin
                    x = 5'(i);
                    ok6 = 1'b1;
                end
            end
            for (int j = 0; j < 8; j++) begin
                if (c4 == T4[j] || (c4 == ~T4[j] &&
                    (($countones(T4[j]) != 2) || j == 3))) begin
                    y = 3'(j);
                    ok4 = 1'b1;
                end
            end
            if (c4 == A7_4B || c4 == ~A7_4B) begin
                y = 3'h7;
                ok4 = 1'b1;
            end
        end
        data = {y, x};
        err = !(ok6 && ok4);
    end
endmodule

// ---- slp_enc.sv ----
/*
 8b/10b encoder, combinational; bit 9 is the first-sent bit a.
 assumes the caller registers the running disparity.
*/
`timescale 1ns/100ps
module slp_enc
    import slp_pkg::*;
(
    input  wire logic [7:0] data,
    input  wire logic       k,
    input  wire logic       rd_in,
    output logic      [9:0] code,
    output logic            rd_out
);
    logic [5:0] c6;
    logic [3:0] c4;
    logic [4:0] x;
    logic [2:0] y;
    logic       rd6;
    logic       alt;

    always_comb begin
        x = data[4:0];
        y = data[7:5];
        c6 = T6[x];
        c4 = T4[y];
        rd6 = rd_in;
        alt = 1'b0;
        if (k) begin
            // only K28.y control codes; whole code flips with disparity
            code = {K28_6B, T4K[y]};
            if (rd_in) begin
                code = ~code;
            end
            rd_out = rd_in ^ ($countones(code) != 5);
        end else begin
            if (rd_in && (($countones(c6) != 3) || x == 5'h07)) begin
                c6 = ~c6;
            end
            rd6 = rd_in ^ ($countones(c6) != 3);
            alt = (y == 3'h7) &&
                  ((!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                   (rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
            if (alt) begin
                c4 = A7_4B;
            end
            if (rd6 && (($countones(c4) != 2) || y == 3'h3)) begin
                c4 = ~c4;
            end
            code = {c6, c4};
            rd_out = rd6 ^ ($countones(c4) != 2);
        end
    end
endmodule

// ---- slp_pcs.sv ----
/*
 one lane of coding datapath between serdes words and core logic,
 with an AHB-Lite register slave (zero wait states, always OKAY).
 assumes serdes and core word timing arrive as one-cycle tick inputs
 on the single clk; reset is synchronous, active high.
*/
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module slp_pcs
    import slp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic [9:0]  rx_word,
    input  wire logic        rx_word_valid,
    input  wire logic        rx_core_tick,
    output logic      [19:0] rx_data,
    output logic             rx_valid,
    output logic             rx_sym_strobe,
    input  wire logic [19:0] tx_data,
    input  wire logic        tx_data_valid,
    output logic             tx_ready,
    input  wire logic        tx_sym_tick,
    output logic      [9:0]  tx_word,
    output logic             tx_word_valid,
    output logic             tx_sym_strobe
);
    typedef struct packed {
        logic [6:0]                 ctrl;
        logic [7:0]                 skip;
        logic                       wr_pend;
        logic [7:0]                 wr_addr;
        logic [31:0]                hrdata;
        logic                       hready_o;
        logic                       hresp_o;
        logic [19:0]                hist;
        logic [3:0]                 offset;
        logic                       aligned;
        logic [2:0]                 los;
        logic [9:0]                 aw;
        logic                       aw_vld;
        logic [EB_DEPTH-1:0][9:0]   eb;
        logic [2:0]                 wp;
        logic [2:0]                 rp;
        logic [3:0]                 cnt;
        logic                       ovf;
        logic                       unf;
        logic [7:0]                 err_cnt;
        logic [7:0]                 ins_cnt;
        logic [7:0]                 del_cnt;
        logic [9:0]                 rx_lo;
        logic                       rx_half;
        logic [19:0]                rx_data;
        logic                       rx_valid;
        logic                       rx_str;
        logic [19:0]                tx_hold;
        logic [1:0]                 tx_slots;
        logic                       tx_ready;
        logic                       tx_rd;
        logic [9:0]                 tx_word;
        logic                       tx_word_valid;
        logic                       tx_str;
    } slp_state_t;

    slp_state_t  s_reg;
    slp_state_t  s_next;
    logic [19:0] hist_in;
    logic [9:0]  win [10];
    logic [9:0]  comma;
    logic [3:0]  first;
    logic        byp;
    logic        ten;
    logic        half;
    logic        take;
    logic        hit;
    logic [31:0] rd_word;
    logic [7:0]  dec_d;
    logic        dec_k;
    logic        dec_err;
    logic [9:0]  entry;
    logic        wr;
    logic        adv;
    logic [9:0]  sym;
    logic [9:0]  tx_sym;
    logic [9:0]  enc_code;
    logic        enc_rd;
    logic [9:0]  w;
    logic [9:0]  wmask;

    assign byp  = s_reg.ctrl[C_BYP];
    assign ten  = s_reg.ctrl[C_TEN];
    assign half = s_reg.ctrl[C_HALF];
    assign take = hsel && htrans[1] && hready;
    assign hit  = (haddr[31:8] == 24'h000000);

    // polarity select ahead of the alignment window
    assign hist_in = {s_reg.hist[9:0],
                      rx_word ^ {10{s_reg.ctrl[C_RXINV]}}};

    genvar g;
    for (g = 0; g < 10; g++) begin : g_win
        assign win[g]   = hist_in[19-g -: 10];
        assign comma[g] = (win[g][9:3] == COMMA_P) ||
                          (win[g][9:3] == COMMA_N);
    end

    always_comb begin
        first = 4'h0;
        for (int i = 9; i >= 0; i--) begin
            if (comma[i]) begin
                first = 4'(i);
            end
        end
    end

    slp_dec u_dec (
        .code (s_reg.aw),
        .data (dec_d),
        .k    (dec_k),
        .err  (dec_err)
    );

    // idle comma when the core has nothing queued, zero symbol in bypass
    assign tx_sym = (s_reg.tx_slots == 2'h0) ?
                    (byp ? 10'h000 : {2'h1, IDLE_CHAR}) :
                    (half && s_reg.tx_slots == 2'h1) ?
                    s_reg.tx_hold[19:10] : s_reg.tx_hold[9:0];

    slp_enc u_enc (
        .data   (tx_sym[7:0]),
        .k      (tx_sym[8]),
        .rd_in  (s_reg.tx_rd),
        .code   (enc_code),
        .rd_out (enc_rd)
    );

    // register read mux; unmapped addresses read zero
    always_comb begin
        rd_word = 32'h00000000;
        if (hit) begin
            case (haddr[7:0])
                A_CTRL: rd_word[6:0] = s_reg.ctrl;
                A_SKIP: rd_word[7:0] = s_reg.skip;
                A_STAT: begin
                    rd_word[ST_ALN]       = s_reg.aligned;
                    rd_word[ST_OVF]       = s_reg.ovf;
                    rd_word[ST_UNF]       = s_reg.unf;
                    rd_word[ST_FILL +: 4] = s_reg.cnt;
                    rd_word[ST_ERR +: 8]  = s_reg.err_cnt;
                    rd_word[ST_INS +: 8]  = s_reg.ins_cnt;
                    rd_word[ST_DEL +: 8]  = s_reg.del_cnt;
                end
                default: rd_word = 32'h00000000;
            endcase
        end
    end

    always_comb begin
        s_next = s_reg;
        s_next.rx_valid = 1'b0;
        s_next.aw_vld = 1'b0;
        s_next.tx_word_valid = 1'b0;
        s_next.rx_str = rx_word_valid;
        s_next.tx_str = tx_sym_tick;
        entry = 10'h000;
        wr = 1'b0;
        adv = 1'b0;
        sym = s_reg.eb[s_reg.rp];
        w = 10'h000;
        wmask = 10'h3FF;

        // bus data phase, then address phase capture
        if (s_reg.wr_pend) begin
            case (s_reg.wr_addr)
                A_CTRL: s_next.ctrl = hwdata[6:0];
                A_SKIP: s_next.skip = hwdata[7:0];
                A_STAT: begin
                    s_next.err_cnt = 8'h00;
                    s_next.ins_cnt = 8'h00;
                    s_next.del_cnt = 8'h00;
                    s_next.ovf = 1'b0;
                    s_next.unf = 1'b0;
                end
                default: ;
            endcase
        end
        s_next.wr_pend = take && hwrite && hit;
        s_next.wr_addr = haddr[7:0];
        if (take && !hwrite) begin
            s_next.hrdata = rd_word;
        end

        // receive word alignment
        if (rx_word_valid) begin
            s_next.hist = hist_in;
            if (!byp && s_reg.ctrl[C_ALIGN] && comma != 10'h000) begin
                s_next.offset = first;
                s_next.aligned = 1'b1;
                s_next.los = 3'h0;
            end
            s_next.aw = win[byp ? 4'h0 : s_next.offset];
            s_next.aw_vld = 1'b1;
        end
        if (byp || !s_reg.ctrl[C_ALIGN]) begin
            s_next.aligned = 1'b0;
        end

        // decoded or raw symbol into the elastic buffer
        if (s_reg.aw_vld) begin
            wr = 1'b1;
            if (byp) begin
                entry = ten ? s_reg.aw : {2'h0, s_reg.aw[7:0]};
            end else begin
                entry = {dec_err, dec_k, dec_d};
                if (dec_err) begin
                    s_next.err_cnt = s_next.err_cnt + 8'h01;
                    s_next.los = s_reg.los + 3'h1;
                    if (s_next.los == LOS_ERRS) begin
                        s_next.aligned = 1'b0;
                        s_next.los = 3'h0;
                    end
                end else begin
                    s_next.los = 3'h0;
                end
                if (s_reg.ctrl[C_COMP] && dec_k && !dec_err &&
                    dec_d == s_reg.skip && s_reg.cnt >= EB_HI) begin
                    wr = 1'b0;
                    s_next.del_cnt = s_next.del_cnt + 8'h01;
                end
            end
            if (wr && s_reg.cnt == EB_FULL) begin
                wr = 1'b0;
                s_next.ovf = 1'b1;
            end
        end

        // core side drain with skip insertion when running low
        if (rx_core_tick) begin
            if (s_reg.cnt == 4'h0) begin
                s_next.unf = 1'b1;
            end else begin
                adv = 1'b1;
                if (!byp && s_reg.ctrl[C_COMP] && s_reg.cnt <= EB_LO &&
                    sym[9:8] == 2'h1 && sym[7:0] == s_reg.skip) begin
                    adv = 1'b0;
                    s_next.ins_cnt = s_next.ins_cnt + 8'h01;
                end
                if (!half) begin
                    s_next.rx_data = {10'h000, sym};
                    s_next.rx_valid = 1'b1;
                end else if (!s_reg.rx_half) begin
                    s_next.rx_lo = sym;
                    s_next.rx_half = 1'b1;
                end else begin
                    s_next.rx_data = {sym, s_reg.rx_lo};
                    s_next.rx_valid = 1'b1;
                    s_next.rx_half = 1'b0;
                end
            end
        end
        if (!half) begin
            s_next.rx_half = 1'b0;
        end

        if (wr) begin
            s_next.eb[s_reg.wp] = entry;
            s_next.wp = s_reg.wp + 3'h1;
        end
        if (adv) begin
            s_next.rp = s_reg.rp + 3'h1;
        end
        case ({wr, adv})
            2'b10:   s_next.cnt = s_reg.cnt + 4'h1;
            2'b01:   s_next.cnt = s_reg.cnt - 4'h1;
            default: s_next.cnt = s_reg.cnt;
        endcase

        // transmit: take core word, emit one symbol per tick
        if (tx_data_valid && s_reg.tx_ready) begin
            s_next.tx_hold = tx_data;
            s_next.tx_slots = half ? 2'h2 : 2'h1;
        end
        if (tx_sym_tick) begin
            if (byp) begin
                w = tx_sym;
                if (!ten) begin
                    wmask = 10'h0FF;
                end
            end else begin
                w = enc_code;
                s_next.tx_rd = enc_rd;
            end
            s_next.tx_word = (w ^ {10{s_reg.ctrl[C_TXINV]}}) & wmask;
            s_next.tx_word_valid = 1'b1;
            if (s_reg.tx_slots != 2'h0) begin
                s_next.tx_slots = s_reg.tx_slots - 2'h1;
            end
        end
        s_next.tx_ready = (s_next.tx_slots == 2'h0);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.ctrl <= CTRL_RST;
            s_reg.skip <= SKIP_RST;
            s_reg.hready_o <= 1'b1;
            s_reg.tx_ready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hreadyout     = s_reg.hready_o;
    assign hresp         = s_reg.hresp_o;
    assign hrdata        = s_reg.hrdata;
    assign rx_data       = s_reg.rx_data;
    assign rx_valid      = s_reg.rx_valid;
    assign rx_sym_strobe = s_reg.rx_str;
    assign tx_ready      = s_reg.tx_ready;
    assign tx_word       = s_reg.tx_word;
    assign tx_word_valid = s_reg.tx_word_valid;
    assign tx_sym_strobe = s_reg.tx_str;
endmodule

// ---- slp_pcs_checker.sv ----
/*
 port timing checker for slp_pcs, bound to every slp_pcs instance.
 assumes one clk and the synchronous active-high reset.
*/
`timescale 1ns/100ps
module slp_pcs_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        rx_word_valid,
    input wire logic        rx_core_tick,
    input wire logic [19:0] rx_data,
    input wire logic        rx_valid,
    input wire logic        rx_sym_strobe,
    input wire logic        tx_data_valid,
    input wire logic        tx_ready,
    input wire logic        tx_sym_tick,
    input wire logic [9:0]  tx_word,
    input wire logic        tx_word_valid,
    input wire logic        tx_sym_strobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence tx_take;
        tx_data_valid && tx_ready;
    endsequence
    sequence no_read;
        !(hsel && htrans[1] && hready && !hwrite);
    endsequence
    bus_okay_a:
        assert property (hreadyout && !hresp)
        else $error("bus slave stalled or not okay");
    rx_strobe_a:
        assert property ($past(reset) || rx_sym_strobe == $past(rx_word_valid))
        else $error("receive strobe off its word");
    tx_strobe_a:
        assert property ($past(reset) || tx_sym_strobe == $past(tx_sym_tick))
        else $error("transmit strobe off its tick");
    tx_pace_a:
        assert property ($past(reset) || tx_word_valid == $past(tx_sym_tick))
        else $error("serializer word not one cycle after tick");
    rx_cause_a:
        assert property (rx_valid |-> $past(rx_core_tick))
        else $error("core word without a core tick");
    rx_hold_a:
        assert property (!rx_valid |-> $stable(rx_data))
        else $error("core word changed without valid");
    tx_hold_a:
        assert property (!tx_word_valid |-> $stable(tx_word))
        else $error("serializer word changed without valid");
    tx_busy_a:
        assert property (tx_take |=> !tx_ready)
        else $error("ready stayed high after a take");
    tx_free_a:
        assert property (tx_take |-> ##[2:40] tx_ready)
        else $error("ready did not return");
    read_hold_a:
        assert property (no_read |=> $stable(hrdata))
        else $error("read data changed without a read");
endmodule

bind slp_pcs slp_pcs_checker chk (
    .clk(clk), .reset(reset), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx_word_valid(rx_word_valid),
    .rx_core_tick(rx_core_tick), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_sym_strobe(rx_sym_strobe),
    .tx_data_valid(tx_data_valid), .tx_ready(tx_ready),
    .tx_sym_tick(tx_sym_tick), .tx_word(tx_word),
    .tx_word_valid(tx_word_valid), .tx_sym_strobe(tx_sym_strobe));

// ---- slp_pkg.sv ----
/*
 constants shared by the lane coding datapath: register map, field
 positions, reset values and 8b/10b code tables.
 assumes a single 200 MHz clock for bus, receive and transmit logic.
*/
package slp_pkg;
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_SKIP    = 8'h04;
    localparam logic [7:0] A_STAT    = 8'h08;
    localparam int         C_RXINV   = 0;
    localparam int         C_TXINV   = 1;
    localparam int         C_BYP     = 2;
    localparam int         C_TEN     = 3;
    localparam int         C_HALF    = 4;
    localparam int         C_ALIGN   = 5;
    localparam int         C_COMP    = 6;
    localparam logic [6:0] CTRL_RST  = 7'h68;
    localparam logic [7:0] SKIP_RST  = 8'h1C;
    localparam logic [7:0] IDLE_CHAR = 8'hBC;
    localparam int         ST_ALN    = 0;
    localparam int         ST_OVF    = 1;
    localparam int         ST_UNF    = 2;
    localparam int         ST_FILL   = 4;
    localparam int         ST_ERR    = 8;
    localparam int         ST_INS    = 16;
    localparam int         ST_DEL    = 24;
    localparam int         EB_DEPTH  = 8;
    localparam logic [3:0] EB_FULL   = 4'h8;
    localparam logic [3:0] EB_HI     = 4'h6;
    localparam logic [3:0] EB_LO     = 4'h2;
    localparam logic [2:0] LOS_ERRS  = 3'h4;
    localparam logic [6:0] COMMA_P   = 7'h1F;
    localparam logic [6:0] COMMA_N   = 7'h60;
    localparam logic [5:0] K28_6B    = 6'h0F;
    localparam logic [3:0] A7_4B     = 4'h7;
    localparam logic [5:0] T6 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] T4 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    localparam logic [3:0] T4K [8] = '{
        4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'hA, 4'h6, 4'h8};
endpackage

// ---- test_serial_lane_pcs_datapath.sv ----
/*
 testbench for slp_pcs: core model on the parallel side, serializer
 words looped back into the receive side.
 assumes 200 MHz clk and synchronous active-high reset.
*/
`timescale 1ns/100ps
module test_serial_lane_pcs_datapath;
    import slp_pkg::*;
    typedef struct packed {
        logic [6:0]  ctrl;
        logic [19:0] w0;
        logic [19:0] w1;
    } slp_row_t;
    localparam int NROW = 9;
    localparam slp_row_t ROWS [NROW] = '{
        '{7'h0C, 20'h002A5, 20'h0015B}, '{7'h0D, 20'h002A5, 20'h0015B},
        '{7'h0E, 20'h00396, 20'h00071}, '{7'h07, 20'h000A5, 20'h0005B},
        '{7'h05, 20'h000A5, 20'h0015B}, '{7'h1C, 20'h5A2A5, 20'h3C15B},
        '{7'h20, 20'h00037, 20'h0013C}, '{7'h23, 20'h000F0, 20'h00001},
        '{7'h30, 20'h3C4A7, 20'h0E081}};
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic        hreadyout, hresp, rx_valid, rx_sym_strobe, tx_ready;
    logic        tx_word_valid, tx_sym_strobe, tx_data_valid, busy;
    logic        rx_core_tick;
    logic [31:0] hrdata, rd;
    logic [19:0] rx_data, tx_data;
    logic [9:0]  tx_word, idl;
    logic [9:0]  rx_word = 10'h0;
    logic        rx_word_valid = 1'b0;
    logic        tx_sym_tick = 1'b0;
    logic        ser_on = 1'b1;
    logic        half = 1'b0;
    logic        send_go = 1'b0;
    logic [19:0] send_word = 20'h0;
    logic [1:0]  tick_gap = 2'h1;
    logic [1:0]  ser_cnt = 2'h0;
    logic [9:0]  e [4];
    logic [9:0]  syms [$];
    logic [9:0]  txq [$];
    slp_row_t    r;
    int          cyc = 0;
    int          n, nexp;
    int          bad_count = 0;
    int          total_checks = 0;

    assign hready = hreadyout;
    always #2.5 clk = ~clk;

    slp_pcs dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
        .rx_core_tick(rx_core_tick), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_sym_strobe(rx_sym_strobe),
        .tx_data(tx_data), .tx_data_valid(tx_data_valid),
        .tx_ready(tx_ready), .tx_sym_tick(tx_sym_tick),
        .tx_word(tx_word), .tx_word_valid(tx_word_valid),
        .tx_sym_strobe(tx_sym_strobe));
    slp_core_model core (.clk(clk), .reset(reset), .tick_gap(tick_gap),
        .send_go(send_go), .send_word(send_word), .busy(busy),
        .tx_data(tx_data), .tx_data_valid(tx_data_valid),
        .tx_ready(tx_ready), .rx_core_tick(rx_core_tick));

    // serializer pace, loopback, capture and timeout
    always @(posedge clk) begin
        ser_cnt <= ser_cnt + 2'h1;
        tx_sym_tick <= ser_on && (ser_cnt == 2'h0);
        rx_word_valid <= tx_word_valid;
        rx_word <= tx_word_valid ? tx_word : ~tx_word;
        cyc <= cyc + 1;
        if (rx_valid === 1'b1) begin
            syms.push_back(rx_data[9:0]);
            if (half) syms.push_back(rx_data[19:10]);
        end
        if (tx_word_valid === 1'b1) txq.push_back(tx_word);
        if (cyc == 6000) begin
            bad_count++;
            finish_test();
        end
    end

    function automatic logic [9:0] exp_sym(logic [6:0] c, logic [9:0] s);
        logic [9:0] m;
        m = (c[C_RXINV] ^ c[C_TXINV]) ? 10'h3FF : 10'h000;
        if (!c[C_BYP]) return {1'b0, s[8:0]};
        if (c[C_TEN]) return s ^ m;
        return {2'b00, s[7:0] ^ m[7:0]};
    endfunction

    task automatic check_reg(input logic [31:0] got, input logic [31:0] x);
        total_checks++;
        if (got !== x) begin
            bad_count++;
            $display("wrong value at %0t: reg %h not %h", $time, got, x);
        end
    endtask

    task automatic check_sym(input logic [9:0] got, input logic [9:0] x);
        total_checks++;
        if (got !== x) begin
            bad_count++;
            $display("wrong value at %0t: sym %h not %h", $time, got, x);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m,
                          input logic [31:0] x);
        ahb(1'b0, a, 32'h0, rd);
        check_reg(rd & m, x);
    endtask

    task automatic send(input logic [19:0] w);
        send_word <= w;
        send_go <= 1'b1;
        @(posedge clk);
        send_go <= 1'b0;
        do @(posedge clk); while (busy !== 1'b0);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < NROW; i++) begin
            r = ROWS[i];
            ahb(1'b1, 32'(A_CTRL), {25'h0, r.ctrl}, rd);
            half = r.ctrl[C_HALF];
            repeat (60) @(posedge clk);
            syms.delete();
            send(r.w0);
            send(r.w1);
            repeat (80) @(posedge clk);
            nexp = half ? 4 : 2;
            e[0] = exp_sym(r.ctrl, r.w0[9:0]);
            e[1] = exp_sym(r.ctrl, half ? r.w0[19:10] : r.w1[9:0]);
            e[2] = exp_sym(r.ctrl, r.w1[9:0]);
            e[3] = exp_sym(r.ctrl, r.w1[19:10]);
            idl = exp_sym(r.ctrl, r.ctrl[C_BYP] ? 10'h0 : {2'b01, IDLE_CHAR});
            n = 0;
            foreach (syms[j]) begin
                if (syms[j] !== idl) begin
                    if (n < nexp) check_sym(syms[j], e[n]);
                    n++;
                end
            end
            check_reg(32'(n), 32'(nexp));
        end
        // reset in mid-run, register map
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        half = 1'b0;
        rd_chk(32'(A_CTRL), 32'hFFFFFFFF, {25'h0, CTRL_RST});
        rd_chk(32'(A_SKIP), 32'hFFFFFFFF, {24'h0, SKIP_RST});
        ahb(1'b1, 32'(A_SKIP), 32'h0000007C, rd);
        ahb(1'b1, 32'h00000100, 32'hFFFFFFFF, rd);
        rd_chk(32'(A_SKIP), 32'hFFFFFFFF, 32'h0000007C);
        rd_chk(32'h00000100, 32'hFFFFFFFF, 32'h0);
        rd_chk(32'(A_CTRL), 32'hFFFFFFFF, {25'h0, CTRL_RST});
        // idle fill alternates disparity
        txq.delete();
        repeat (20) @(posedge clk);
        check_sym(txq[1], ~txq[0]);
        check_sym(txq[0] === 10'h0FA ? 10'h0FA : 10'h305, txq[0]);
        // core stall: overflow, clear, then slow drain to underflow
        tick_gap <= 2'h0;
        repeat (60) @(posedge clk);
        rd_chk(32'(A_STAT), 32'h000000F2, 32'h00000082);
        ser_on <= 1'b0;
        repeat (10) @(posedge clk);
        ahb(1'b1, 32'(A_STAT), 32'h0, rd);
        rd_chk(32'(A_STAT), 32'h0000FFF6, 32'h00000080);
        tick_gap <= 2'h3;
        ser_on <= 1'b1;
        repeat (150) @(posedge clk);
        rd_chk(32'(A_STAT), 32'h00000004, 32'h00000004);
        finish_test();
    end
endmodule
